// *** inc/gsc_pkg.sv ***
// constants and types shared by the gas sensor command interface
package gsc_pkg;
  // clock and timing
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int MS_PER_S = 1000;
  localparam int SAMPLE_INTERVAL_MS = 5000;
  localparam int HALT_QUIET_MS = 500;
  localparam int SAMPLE_CYCLES = (CLK_FREQ_HZ / MS_PER_S) * SAMPLE_INTERVAL_MS;
  localparam int QUIET_CYCLES = (CLK_FREQ_HZ / MS_PER_S) * HALT_QUIET_MS;
  // command codes
  localparam logic [15:0] CMD_START = 16'h21B1;
  localparam logic [15:0] CMD_FETCH = 16'hEC05;
  localparam logic [15:0] CMD_HALT = 16'h3F86;
  localparam logic [15:0] CMD_BIAS = 16'h241D;
  localparam logic [15:0] CMD_PRESS = 16'hE000;
  localparam logic [15:0] CMD_COMMIT = 16'h3615;
  // checksum
  localparam logic [7:0] CRC_POLY = 8'h31;
  localparam logic [7:0] CRC_INIT = 8'hFF;
  // framing
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int CMD_BYTES = 2;
  localparam int PARAM_END = 5;
  localparam int WORD_BYTES = 3;
  localparam int SET_WORDS = 3;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  // settings and scaling
  localparam int TEMP_SPAN_C = 175;
  localparam int WORD_FULL = 65535;
  localparam int OFFSET_DEF_C = 4;
  localparam logic [15:0] OFFSET_DEF =
    16'((OFFSET_DEF_C * WORD_FULL + TEMP_SPAN_C / 2) / TEMP_SPAN_C);
  localparam int PRESS_DEF_PA = 101300;
  localparam int PRESS_SCALE = 100;
  localparam logic [15:0] PRESS_DEF = 16'(PRESS_DEF_PA / PRESS_SCALE);
  localparam logic [15:0] WORD_MAX = 16'hFFFF;
  localparam int RH_COMP_SHIFT = 16;
  localparam int GAS_RH_SHIFT = 12;
  // operating modes and read sources
  typedef enum {MODE_IDLE, MODE_RUN, MODE_QUIET} gsc_mode_t;
  typedef enum {SRC_NONE, SRC_FETCH, SRC_PRESS} gsc_src_t;
endpackage : gsc_pkg

// *** inc/gsc_stream_if.sv ***
// byte stream carrier with valid, ready and flush
`timescale 1ns/10ps
interface gsc_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic flush;
  logic [W-1:0] data;
  modport prod (output valid, output data, output flush, input ready);
  modport cons (input valid, input data, input flush, output ready);
endinterface : gsc_stream_if

// *** src/gsc_crc8.sv ***
// checksum over one 16-bit word, high byte first
`timescale 1ns/10ps
module gsc_crc8 (
  input wire logic [15:0] word,
  output logic [7:0] crc
);
  logic [7:0] c;
  logic fb;

  // bitwise shift register, msb of the word first
  always_comb begin
    c = gsc_pkg::CRC_INIT;
    fb = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      fb = c[7] ^ word[i];
      c = {c[6:0], 1'b0} ^ (fb ? gsc_pkg::CRC_POLY : 8'h00);
    end
    crc = c;
  end
endmodule : gsc_crc8

// *** src/gsc_fifo.sv ***
// parameterised byte fifo with flush
`timescale 1ns/10ps
module gsc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  gsc_stream_if.cons wr,
  gsc_stream_if.prod rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  // handshakes; flush blocks both sides for its cycle
  assign wr.ready = (cnt_reg != (AW+1)'(DEPTH)) && !wr.flush;
  assign rd.valid = (cnt_reg != '0) && !wr.flush;
  assign rd.data = mem[rp_reg];
  assign rd.flush = 1'b0;
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_reg] <= wr.data;
    end
  end

  // write pointer
  always_ff @(posedge clk) begin
    if (rst || wr.flush) begin
      wp_reg <= '0;
    end else if (push) begin
      wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
    end
  end

  // read pointer
  always_ff @(posedge clk) begin
    if (rst || wr.flush) begin
      rp_reg <= '0;
    end else if (pop) begin
      rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
    end
  end

  // fill level
  always_ff @(posedge clk) begin
    if (rst || wr.flush) begin
      cnt_reg <= '0;
    end else if (push && !pop) begin
      cnt_reg <= cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  chk_fifo_level_bound: assert property (@(posedge clk) disable iff (rst)
    cnt_reg <= (AW+1)'(DEPTH)) else $error("fifo level above depth");
  chk_fifo_flush_empties: assert property (@(posedge clk)
    disable iff (rst) wr.flush |=> !rd.valid) else $error("fifo not flushed");
endmodule : gsc_fifo

// *** src/gsc_top.sv ***
// gas sensor command interpreter behind an i2c byte engine
`timescale 1ns/10ps
module gsc_top #(
  parameter int SAMPLE_CYCLES = gsc_pkg::SAMPLE_CYCLES,
  parameter int QUIET_CYCLES = gsc_pkg::QUIET_CYCLES,
  parameter int FIFO_DEPTH = gsc_pkg::FIFO_DEPTH
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic WR_BEGIN,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  output logic RX_ACK,
  input wire logic RD_BEGIN,
  output logic RD_ACK,
  input wire logic TX_REQ,
  output logic [7:0] TX_DATA,
  input wire logic BYTE_NACK,
  input wire logic BUS_STOP,
  input wire logic [15:0] SENSE_GAS,
  input wire logic [15:0] SENSE_TEMP,
  input wire logic [15:0] SENSE_RH,
  output logic SAMPLING,
  output logic PERSIST_STROBE,
  output logic [15:0] PERSIST_OFFSET,
  output logic [15:0] PERSIST_PRESS
);
  localparam int BW = gsc_pkg::BYTE_W;
  gsc_pkg::gsc_mode_t mode_reg;
  gsc_pkg::gsc_src_t src_reg;
  logic [2:0] rx_cnt_reg;
  logic wr_phase_reg;
  logic [15:0] cmd_reg, par_reg;
  logic [7:0] par_crc_reg;
  logic [31:0] samp_cnt_reg, quiet_cnt_reg;
  logic tick, tick_pend_reg, fill_start, fill_busy_reg;
  logic [1:0] widx_reg, bidx_reg, pidx_reg;
  logic [15:0] set_reg [gsc_pkg::SET_WORDS];
  logic [15:0] offset_reg, press_reg, fill_word;
  logic [7:0] par_crc, fill_crc, press_crc;
  logic rd_active_reg, rd_end;
  logic done, n2, n5, par_ok;
  logic go_start, go_halt, go_fetch, go_pread, go_pwrite, go_bias, go_commit;
  logic [15:0] temp_c, rh_c, gas_c;
  logic [31:0] rh_prod;
  logic [16:0] rh_sum, gas_sum;
  logic [7:0] hi_b, lo_b;

  gsc_stream_if #(.W(BW)) fin ();
  gsc_stream_if #(.W(BW)) fout ();

  gsc_fifo #(.W(BW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CLK_SYS),
    .rst(RST),
    .wr(fin),
    .rd(fout)
  );
  gsc_crc8 u_crc_par (.word(par_reg), .crc(par_crc));
  gsc_crc8 u_crc_fill (.word(fill_word), .crc(fill_crc));
  gsc_crc8 u_crc_press (.word(press_reg), .crc(press_crc));

  // command decode at the stop that closes a write transfer
  assign done = BUS_STOP && wr_phase_reg && mode_reg != gsc_pkg::MODE_QUIET;
  assign n2 = rx_cnt_reg == 3'(gsc_pkg::CMD_BYTES);
  assign n5 = rx_cnt_reg == 3'(gsc_pkg::PARAM_END);
  assign par_ok = par_crc == par_crc_reg;
  assign go_start = done && n2 && cmd_reg == gsc_pkg::CMD_START
    && mode_reg == gsc_pkg::MODE_IDLE;
  assign go_halt = done && n2 && cmd_reg == gsc_pkg::CMD_HALT
    && mode_reg == gsc_pkg::MODE_RUN;
  assign go_fetch = done && n2 && cmd_reg == gsc_pkg::CMD_FETCH;
  assign go_pread = done && n2 && cmd_reg == gsc_pkg::CMD_PRESS;
  assign go_pwrite = done && n5 && cmd_reg == gsc_pkg::CMD_PRESS
    && par_ok;
  assign go_bias = done && n5 && cmd_reg == gsc_pkg::CMD_BIAS && par_ok
    && mode_reg == gsc_pkg::MODE_IDLE;
  assign go_commit = done && n2 && cmd_reg == gsc_pkg::CMD_COMMIT
    && mode_reg == gsc_pkg::MODE_IDLE;

  // bytes are refused during the quiet time and past the longest frame
  assign RX_ACK = wr_phase_reg && mode_reg != gsc_pkg::MODE_QUIET
    && rx_cnt_reg != 3'(gsc_pkg::PARAM_END);

  // write phase tracking
  always_ff @(posedge CLK_SYS) begin
    if (RST || BUS_STOP || RD_BEGIN) begin
      wr_phase_reg <= 1'b0;
    end else if (WR_BEGIN) begin
      wr_phase_reg <= 1'b1;
    end
  end

  // received byte assembly, high byte first
  always_ff @(posedge CLK_SYS) begin
    if (RST || WR_BEGIN) begin
      rx_cnt_reg <= '0;
    end else if (RX_VALID && RX_ACK) begin
      rx_cnt_reg <= rx_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      cmd_reg <= '0;
      par_reg <= '0;
      par_crc_reg <= '0;
    end else if (RX_VALID && RX_ACK) begin
      if (rx_cnt_reg < 3'(gsc_pkg::CMD_BYTES)) begin
        cmd_reg <= {cmd_reg[BW-1:0], RX_DATA};
      end else if (rx_cnt_reg < 3'(gsc_pkg::PARAM_END - 1)) begin
        par_reg <= {par_reg[BW-1:0], RX_DATA};
      end else begin
        par_crc_reg <= RX_DATA;
      end
    end
  end

  // operating mode
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      mode_reg <= gsc_pkg::MODE_IDLE;
    end else begin
      case (mode_reg)
        gsc_pkg::MODE_IDLE: begin
          if (go_start) begin
            mode_reg <= gsc_pkg::MODE_RUN;
          end
        end
        gsc_pkg::MODE_RUN: begin
          if (go_halt) begin
            mode_reg <= gsc_pkg::MODE_QUIET;
          end
        end
        gsc_pkg::MODE_QUIET: begin
          if (quiet_cnt_reg == 32'(QUIET_CYCLES - 1)) begin
            mode_reg <= gsc_pkg::MODE_IDLE;
          end
        end
        default: mode_reg <= gsc_pkg::MODE_IDLE;
      endcase
    end
  end
  assign SAMPLING = mode_reg == gsc_pkg::MODE_RUN;

  // quiet time counter after halt
  always_ff @(posedge CLK_SYS) begin
    if (RST || mode_reg != gsc_pkg::MODE_QUIET) begin
      quiet_cnt_reg <= '0;
    end else begin
      quiet_cnt_reg <= quiet_cnt_reg + 1'b1;
    end
  end

  // sample interval timer
  assign tick = SAMPLING && samp_cnt_reg == 32'(SAMPLE_CYCLES - 1);
  always_ff @(posedge CLK_SYS) begin
    if (RST || !SAMPLING || tick) begin
      samp_cnt_reg <= '0;
    end else begin
      samp_cnt_reg <= samp_cnt_reg + 1'b1;
    end
  end

  // settings: offset and pressure, with commit snapshot
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      offset_reg <= gsc_pkg::OFFSET_DEF;
      press_reg <= gsc_pkg::PRESS_DEF;
    end else begin
      if (go_bias) begin
        offset_reg <= par_reg;
      end
      if (go_pwrite) begin
        press_reg <= par_reg;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PERSIST_STROBE <= 1'b0;
      PERSIST_OFFSET <= gsc_pkg::OFFSET_DEF;
      PERSIST_PRESS <= gsc_pkg::PRESS_DEF;
    end else begin
      PERSIST_STROBE <= go_commit;
      if (go_commit) begin
        PERSIST_OFFSET <= offset_reg;
        PERSIST_PRESS <= press_reg;
      end
    end
  end

  // compensation; offset touches only temperature and humidity
  always_comb begin
    temp_c = (SENSE_TEMP > offset_reg) ? SENSE_TEMP - offset_reg : '0;
    rh_prod = 32'(SENSE_RH) * 32'(offset_reg);
    rh_sum = 17'(SENSE_RH) + 17'(rh_prod >> gsc_pkg::RH_COMP_SHIFT);
    rh_c = rh_sum[16] ? gsc_pkg::WORD_MAX : rh_sum[15:0];
    gas_sum = 17'(SENSE_GAS) + 17'(SENSE_RH >> gsc_pkg::GAS_RH_SHIFT);
    gas_c = gas_sum[16] ? gsc_pkg::WORD_MAX : gas_sum[15:0];
  end

  // a new set waits while a read is in progress
  assign fill_start = tick_pend_reg && !rd_active_reg;
  always_ff @(posedge CLK_SYS) begin
    if (RST || (fill_start && !tick)) begin
      tick_pend_reg <= 1'b0;
    end else if (tick) begin
      tick_pend_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (tick) begin
      set_reg[0] <= gas_c;
      set_reg[1] <= temp_c;
      set_reg[2] <= rh_c;
    end
  end

  // fill sequencer: word hi, word lo, crc, three times
  assign fill_word = set_reg[widx_reg];
  assign {hi_b, lo_b} = fill_word;
  assign fin.valid = fill_busy_reg;
  assign fin.data = (bidx_reg == 2'h0) ? hi_b :
    (bidx_reg == 2'h1) ? lo_b : fill_crc;
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      fill_busy_reg <= 1'b0;
      widx_reg <= '0;
      bidx_reg <= '0;
    end else if (fill_start) begin
      fill_busy_reg <= 1'b1;
      widx_reg <= '0;
      bidx_reg <= '0;
    end else if (fill_busy_reg && fin.ready) begin
      if (bidx_reg == 2'(gsc_pkg::WORD_BYTES - 1)) begin
        bidx_reg <= '0;
        widx_reg <= widx_reg + 1'b1;
        if (widx_reg == 2'(gsc_pkg::SET_WORDS - 1)) begin
          fill_busy_reg <= 1'b0;
          widx_reg <= '0; // keeps the word index inside the set
        end
      end else begin
        bidx_reg <= bidx_reg + 1'b1;
      end
    end
  end

  // read phase: ack, pops and early end
  assign RD_ACK = RD_BEGIN && ((src_reg == gsc_pkg::SRC_FETCH
    && fout.valid && !fill_busy_reg)
    || src_reg == gsc_pkg::SRC_PRESS);
  assign rd_end = rd_active_reg && (BYTE_NACK || BUS_STOP);
  assign fout.ready = TX_REQ && rd_active_reg
    && src_reg == gsc_pkg::SRC_FETCH;
  assign fin.flush = fill_start
    || (rd_end && src_reg == gsc_pkg::SRC_FETCH);

  always_ff @(posedge CLK_SYS) begin
    if (RST || rd_end || (RD_BEGIN && !RD_ACK)) begin
      rd_active_reg <= 1'b0;
    end else if (RD_ACK) begin
      rd_active_reg <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST || rd_end || (RD_BEGIN && !RD_ACK)) begin
      src_reg <= gsc_pkg::SRC_NONE;
    end else if (go_fetch) begin
      src_reg <= gsc_pkg::SRC_FETCH;
    end else if (go_pread) begin
      src_reg <= gsc_pkg::SRC_PRESS;
    end
  end

  // transmit byte register
  always_ff @(posedge CLK_SYS) begin
    if (RST || RD_BEGIN) begin
      TX_DATA <= gsc_pkg::IDLE_BYTE;
      pidx_reg <= '0;
    end else if (TX_REQ && rd_active_reg) begin
      if (src_reg == gsc_pkg::SRC_FETCH) begin
        TX_DATA <= fout.valid ? fout.data : gsc_pkg::IDLE_BYTE;
      end else begin
        pidx_reg <= pidx_reg + 1'b1;
        TX_DATA <= (pidx_reg == 2'h0) ? press_reg[15:BW] :
          (pidx_reg == 2'h1) ? press_reg[BW-1:0] :
          (pidx_reg == 2'h2) ? press_crc : gsc_pkg::IDLE_BYTE;
      end
    end
  end

  chk_powerup_idle: assert property (@(posedge CLK_SYS)
    disable iff (1'b0) RST |=> mode_reg == gsc_pkg::MODE_IDLE && !SAMPLING)
    else $error("not idle after power-up");
  chk_start_enters_run: assert property (@(posedge CLK_SYS)
    disable iff (RST) go_start |=> SAMPLING && samp_cnt_reg == '0)
    else $error("start did not enter sampling");
  chk_tick_fills_set: assert property (@(posedge CLK_SYS)
    disable iff (RST) tick && !rd_active_reg && !RD_ACK |=> fill_start
    ##1 fill_busy_reg) else $error("sample tick did not refill");
  chk_empty_fetch_nack: assert property (@(posedge CLK_SYS)
    disable iff (RST) RD_BEGIN && src_reg == gsc_pkg::SRC_FETCH
    && !fout.valid |-> !RD_ACK) else $error("empty buffer acked");
  chk_read_clears_buf: assert property (@(posedge CLK_SYS)
    disable iff (RST) rd_end && src_reg == gsc_pkg::SRC_FETCH && !fill_start
    |=> !fout.valid && src_reg == gsc_pkg::SRC_NONE)
    else $error("buffer kept after read");
  chk_nack_ends_read: assert property (@(posedge CLK_SYS)
    disable iff (RST) rd_active_reg && BYTE_NACK |=> !rd_active_reg
    ##1 (!rd_active_reg || $past(RD_ACK)))
    else $error("read continued after nack");
  chk_halt_quiet_time: assert property (@(posedge CLK_SYS)
    disable iff (RST) go_halt |=> mode_reg == gsc_pkg::MODE_QUIET && !RX_ACK)
    else $error("halt did not start quiet time");
  chk_quiet_ignores: assert property (@(posedge CLK_SYS)
    disable iff (RST) mode_reg == gsc_pkg::MODE_QUIET |-> !RX_ACK ##1
    mode_reg != gsc_pkg::MODE_RUN && offset_reg == $past(offset_reg)
    && press_reg == $past(press_reg) && !PERSIST_STROBE)
    else $error("command taken during quiet time");
  chk_bias_updates: assert property (@(posedge CLK_SYS)
    disable iff (RST) go_bias |=> offset_reg == $past(par_reg))
    else $error("offset not written");
  chk_offset_default: assert property (@(posedge CLK_SYS)
    disable iff (1'b0) RST |=> offset_reg == gsc_pkg::OFFSET_DEF)
    else $error("offset default wrong");
  chk_gas_no_offset: assert property (@(posedge CLK_SYS)
    disable iff (RST) tick |=> set_reg[0] == $past(gas_c))
    else $error("gas word altered");

  cov_start: cover property (@(posedge CLK_SYS) disable iff (RST) go_start);
  cov_fetch_read: cover property (@(posedge CLK_SYS) disable iff (RST)
    RD_ACK && src_reg == gsc_pkg::SRC_FETCH);
  cov_halt: cover property (@(posedge CLK_SYS) disable iff (RST) go_halt);
  cov_bias: cover property (@(posedge CLK_SYS) disable iff (RST) go_bias);
endmodule : gsc_top

// *** test/gsc_master_model.sv ***
// byte-level bus master model that drives the command interpreter
`timescale 1ns/10ps
module gsc_master_model (
  input wire logic clk,
  output logic wr_begin,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ack,
  output logic rd_begin,
  input wire logic rd_ack,
  output logic tx_req,
  input wire logic [7:0] tx_data,
  output logic byte_nack,
  output logic bus_stop
);
  // all strobes idle at time zero
  initial begin
    wr_begin = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    rd_begin = 1'b0;
    tx_req = 1'b0;
    byte_nack = 1'b0;
    bus_stop = 1'b0;
  end

  // write transfer of n bytes, then stop; acks sampled per byte
  task automatic wr(input logic [39:0] b, input int n,
                    output logic [4:0] acks);
    acks = 5'h00;
    @(posedge clk);
    wr_begin <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      wr_begin <= 1'b0;
      rx_valid <= 1'b1;
      rx_data <= b[8 * (n - 1 - i) +: 8];
      @(negedge clk);
      acks[i] = rx_ack;
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data; // released line must not keep the byte
    bus_stop <= 1'b1;
    @(posedge clk);
    bus_stop <= 1'b0;
  endtask : wr

  // read transfer of n bytes, ended by nack and stop
  task automatic rd(input int n, output logic ack, output logic [71:0] q);
    q = 72'h0;
    @(posedge clk);
    rd_begin <= 1'b1;
    @(negedge clk);
    ack = rd_ack;
    @(posedge clk);
    rd_begin <= 1'b0;
    if (ack === 1'b1) begin
      for (int i = 0; i < n; i++) begin
        tx_req <= 1'b1;
        @(posedge clk);
        tx_req <= 1'b0;
        @(negedge clk);
        q = {q[63:0], tx_data};
        @(posedge clk);
      end
      byte_nack <= 1'b1;
      @(posedge clk);
      byte_nack <= 1'b0;
    end
    bus_stop <= 1'b1;
    @(posedge clk);
    bus_stop <= 1'b0;
  endtask : rd
endmodule : gsc_master_model

// *** test/tb.sv ***
// self-checking bench for the gas sensor command interface
`timescale 1ns/10ps
module tb;
  localparam int QUIET = 20;
  logic clk_sys, rst, wr_begin, rx_valid, rx_ack, rd_begin, rd_ack;
  logic tx_req, byte_nack, bus_stop, sampling, persist_strobe;
  logic [7:0] rx_data, tx_data;
  logic [15:0] sense_gas, sense_temp, sense_rh, persist_offset;
  logic [15:0] persist_press;
  int num_errors = 0;
  int n_tests = 0;
  int strobes = 0;

  gsc_top #(.SAMPLE_CYCLES(100), .QUIET_CYCLES(QUIET), .FIFO_DEPTH(16)) DUT (
    .CLK_SYS(clk_sys), .RST(rst), .WR_BEGIN(wr_begin), .RX_VALID(rx_valid),
    .RX_DATA(rx_data), .RX_ACK(rx_ack), .RD_BEGIN(rd_begin),
    .RD_ACK(rd_ack), .TX_REQ(tx_req), .TX_DATA(tx_data),
    .BYTE_NACK(byte_nack), .BUS_STOP(bus_stop), .SENSE_GAS(sense_gas),
    .SENSE_TEMP(sense_temp), .SENSE_RH(sense_rh), .SAMPLING(sampling),
    .PERSIST_STROBE(persist_strobe), .PERSIST_OFFSET(persist_offset),
    .PERSIST_PRESS(persist_press));

  gsc_master_model u_m (
    .clk(clk_sys), .wr_begin(wr_begin), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ack(rx_ack), .rd_begin(rd_begin),
    .rd_ack(rd_ack), .tx_req(tx_req), .tx_data(tx_data),
    .byte_nack(byte_nack), .bus_stop(bus_stop));

  // 10 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // count save pulses
  always @(posedge clk_sys) begin
    if (persist_strobe === 1'b1) strobes++;
  end

  task automatic final_report;
    $display("comparisons %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [71:0] e,
                     input logic [71:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, e, g);
    end
  endtask : chk

  // word followed by its checksum
  function automatic logic [23:0] grp(input logic [15:0] w);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ w[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
    end
    return {w, c};
  endfunction : grp

  // expected nine-byte sample set from raw inputs and offset
  function automatic logic [71:0] exp_set(input logic [15:0] g,
      input logic [15:0] t, input logic [15:0] h, input logic [15:0] off);
    logic [31:0] hs;
    logic [31:0] gs;
    logic [15:0] ts;
    hs = 32'(h) + ((32'(h) * 32'(off)) >> 16);
    gs = 32'(g) + 32'(h >> 12);
    ts = (t > off) ? t - off : 16'h0000;
    if (hs > 32'h0000FFFF) hs = 32'h0000FFFF;
    if (gs > 32'h0000FFFF) gs = 32'h0000FFFF;
    return {grp(gs[15:0]), grp(ts), grp(hs[15:0])};
  endfunction : exp_set

  task automatic send(input logic [39:0] b, input int n);
    logic [4:0] a;
    u_m.wr(b, n, a);
    chk("write ack", 72'(5'h1F >> (5 - n)), 72'(a));
  endtask : send

  task automatic fetch(input int n, input logic ae, input logic [71:0] qe);
    logic a;
    logic [71:0] q;
    send({24'h0, gsc_pkg::CMD_FETCH}, 2);
    u_m.rd(n, a, q);
    chk("fetch ack", 72'(ae), 72'(a));
    if (ae) chk("fetch data", qe >> (8 * (9 - n)), q);
  endtask : fetch

  task automatic commit(input logic [15:0] off, input logic [15:0] pr);
    int s0;
    s0 = strobes;
    send({24'h0, gsc_pkg::CMD_COMMIT}, 2);
    repeat (3) @(negedge clk_sys);
    chk("strobe count", 72'(1), 72'(strobes - s0));
    chk("saved offset", 72'(off), 72'(persist_offset));
    chk("saved pressure", 72'(pr), 72'(persist_press));
  endtask : commit

  task automatic t_powerup;
    @(negedge clk_sys);
    chk("sampling", 72'(1'b0), 72'(sampling));
    chk("idle byte", 72'(8'hFF), 72'(tx_data));
    chk("offset default", 72'(16'h05DA), 72'(persist_offset));
    chk("pressure default", 72'(16'h03F5), 72'(persist_press));
  endtask : t_powerup

  // idle: empty fetch, bad and good offset writes
  task automatic t_idle;
    fetch(9, 1'b0, 72'h0);
    send({gsc_pkg::CMD_BIAS, 16'h07E6, 8'h00}, 5);
    commit(16'h05DA, 16'h03F5);
    send({gsc_pkg::CMD_BIAS, grp(16'h07E6)}, 5);
    commit(16'h07E6, 16'h03F5);
  endtask : t_idle

  // sampling: interval, read once, pressure access
  task automatic t_run;
    logic a;
    logic [71:0] q;
    send({24'h0, gsc_pkg::CMD_START}, 2);
    @(negedge clk_sys);
    chk("sampling on", 72'(1'b1), 72'(sampling));
    repeat (85) @(posedge clk_sys);
    fetch(9, 1'b0, 72'h0);
    repeat (20) @(posedge clk_sys);
    fetch(9, 1'b1, exp_set(16'h01F4, 16'h6667, 16'h5EB9, 16'h07E6));
    fetch(9, 1'b0, 72'h0);
    send({gsc_pkg::CMD_PRESS, grp(16'h03DB)}, 5);
    send({24'h0, gsc_pkg::CMD_PRESS}, 2);
    u_m.rd(3, a, q);
    chk("pressure ack", 72'(1'b1), 72'(a));
    chk("pressure word", 72'(grp(16'h03DB)), q);
    sense_gas <= 16'hF000;
    repeat (40) @(posedge clk_sys);
    fetch(2, 1'b1, exp_set(16'hF000, 16'h6667, 16'h5EB9, 16'h07E6));
    fetch(9, 1'b0, 72'h0);
  endtask : t_run

  // halt, quiet time, then save and restart
  task automatic t_halt;
    logic [4:0] a;
    send({24'h0, gsc_pkg::CMD_HALT}, 2);
    @(negedge clk_sys);
    chk("sampling off", 72'(1'b0), 72'(sampling));
    u_m.wr({24'h0, gsc_pkg::CMD_START}, 2, a);
    chk("quiet ack", 72'h0, 72'(a));
    @(negedge clk_sys);
    chk("quiet start", 72'(1'b0), 72'(sampling));
    repeat (QUIET + 5) @(posedge clk_sys);
    commit(16'h07E6, 16'h03DB);
    send({24'h0, gsc_pkg::CMD_START}, 2);
    @(negedge clk_sys);
    chk("restart", 72'(1'b1), 72'(sampling));
  endtask : t_halt

  // main sequence
  initial begin
    rst = 1'b1;
    sense_gas = 16'h01F4;
    sense_temp = 16'h6667;
    sense_rh = 16'h5EB9;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_powerup();
    t_idle();
    t_run();
    t_halt();
    final_report();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge clk_sys);
    num_errors++;
    final_report();
  end
endmodule : tb
